// ===== common/lan_event_consts.svh
`ifndef LAN_EVENT_CONSTS_SVH
`define LAN_EVENT_CONSTS_SVH

// flag positions in the packed flag vector
`define FLAG_NO_ACK 0
`define FLAG_TX_DONE 1
`define FLAG_PARITY 2
`define FLAG_HOST_WAKE 3
`define FLAG_BUS_WAKE 4
`define FLAG_POS_GND 5
`define FLAG_NEG_GND 6
`define FLAG_COUNT 7
`define FLAG_RESET 7'h00
`define BUS_PASSIVE 1'b0

`endif

// ===== common/lan_event_pkg.sv
package lan_event_pkg;
    // which pin wakes the device on the host side
    typedef enum logic {
        WAKE_ON_RX,
        WAKE_ON_CS
    } wake_src_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_WAIT_RESP
    } tx_state_t;
endpackage

// ===== design/pin_sync.sv
`timescale 1ns/1ps
`include "lan_event_consts.svh"

// three-stage synchroniser; change counts when stages two and three differ
module pin_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pin and result
    input wire logic pinIn,
    output logic pinOut,
    output logic pinChange
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign pinOut = s3_q;
    assign pinChange = s2_q != s3_q;
endmodule

// ===== design/lan_event_flag_logic.sv
`timescale 1ns/1ps
`include "lan_event_consts.svh"

// Contract
// - no-ack flag after all retries unanswered
// - tx-done flag on clean message end
// - no tx-done when requested response fails
// - parity flag on host link parity error
// - rx variant: rx pin change wakes
// - cs variant: chip select change wakes
// - bus wake on passive to dominant
// - positive line ground short flag
// - negative line ground short flag
module lan_event_flag_logic (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration
    input wire lan_event_pkg::wake_src_t wakeSrc,
    input wire logic sleepMode,
    // transmit engine events
    input wire logic retryExhausted,
    input wire logic anyAck,
    input wire logic txEnd,
    input wire logic txOk,
    input wire logic respRequested,
    input wire logic respEnd,
    input wire logic respOk,
    // host link events
    input wire logic hostParityErr,
    // pins
    input wire logic rxPin,
    input wire logic csPin,
    input wire logic busLevel,
    input wire logic posGndShort,
    input wire logic negGndShort,
    // flag clear from host, one bit per flag
    input wire logic [6:0] flagClear,
    // flags
    output logic no_ack_flag,
    output logic tx_done_flag,
    output logic host_parity_err_flag,
    output logic host_wake_flag,
    output logic bus_wake_flag,
    output logic pos_line_gnd_short_flag,
    output logic neg_line_gnd_short_flag,
    output logic anyFlag
);
    import lan_event_pkg::*;

    // ************************************
    // pin synchronisers
    // ************************************
    logic rxChg, csChg, busS, busChg, posS, posChg, negS, negChg;
    pin_sync uRx (.core_clk(core_clk), .rst(rst), .pinIn(rxPin), .pinOut(), .pinChange(rxChg));
    pin_sync uCs (.core_clk(core_clk), .rst(rst), .pinIn(csPin), .pinOut(), .pinChange(csChg));
    pin_sync uBus (.core_clk(core_clk), .rst(rst), .pinIn(busLevel), .pinOut(busS),
        .pinChange(busChg));
    pin_sync uPos (.core_clk(core_clk), .rst(rst), .pinIn(posGndShort), .pinOut(posS),
        .pinChange(posChg));
    pin_sync uNeg (.core_clk(core_clk), .rst(rst), .pinIn(negGndShort), .pinOut(negS),
        .pinChange(negChg));

    // ************************************
    // transmit outcome tracking
    // ************************************
    tx_state_t txState_q;
    logic txDoneEv;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txState_q <= TX_IDLE;
        end else begin
            case (txState_q)
                TX_IDLE: begin
                    if (txEnd && txOk && respRequested) begin
                        txState_q <= TX_WAIT_RESP;
                    end
                end
                TX_WAIT_RESP: begin
                    if (respEnd) begin
                        txState_q <= TX_IDLE;
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                end
            endcase
        end
    end

    assign txDoneEv = (txState_q == TX_IDLE && txEnd && txOk && !respRequested)
        || (txState_q == TX_WAIT_RESP && respEnd && respOk);

    // ************************************
    // event vector
    // ************************************
    logic [`FLAG_COUNT-1:0] ev;
    logic wakeChg;
    assign wakeChg = (wakeSrc == WAKE_ON_RX) ? rxChg : csChg;

    always_comb begin
        ev = `FLAG_RESET;
        ev[`FLAG_NO_ACK] = retryExhausted && !anyAck;
        ev[`FLAG_TX_DONE] = txDoneEv;
        ev[`FLAG_PARITY] = hostParityErr;
        ev[`FLAG_HOST_WAKE] = sleepMode && wakeChg;
        ev[`FLAG_BUS_WAKE] = sleepMode && busChg && (busS == `BUS_PASSIVE);
        ev[`FLAG_POS_GND] = posChg && !posS;
        ev[`FLAG_NEG_GND] = negChg && !negS;
    end

    // ************************************
    // sticky flags
    // ************************************
    logic [`FLAG_COUNT-1:0] flags_q;
    logic [`FLAG_COUNT-1:0] flags_d;
    assign flags_d = (flags_q & ~flagClear) | ev;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_q <= `FLAG_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            no_ack_flag <= 1'b0;
            tx_done_flag <= 1'b0;
            host_parity_err_flag <= 1'b0;
            host_wake_flag <= 1'b0;
            bus_wake_flag <= 1'b0;
            pos_line_gnd_short_flag <= 1'b0;
            neg_line_gnd_short_flag <= 1'b0;
            anyFlag <= 1'b0;
        end else begin
            no_ack_flag <= flags_d[`FLAG_NO_ACK];
            tx_done_flag <= flags_d[`FLAG_TX_DONE];
            host_parity_err_flag <= flags_d[`FLAG_PARITY];
            host_wake_flag <= flags_d[`FLAG_HOST_WAKE];
            bus_wake_flag <= flags_d[`FLAG_BUS_WAKE];
            pos_line_gnd_short_flag <= flags_d[`FLAG_POS_GND];
            neg_line_gnd_short_flag <= flags_d[`FLAG_NEG_GND];
            anyFlag <= |flags_d;
        end
    end

    // ************************************
    // checks
    // ************************************
    // outputs gathered in flag order, for the checks below
    logic [`FLAG_COUNT-1:0] flagOut;
    assign flagOut = {neg_line_gnd_short_flag, pos_line_gnd_short_flag, bus_wake_flag,
        host_wake_flag, host_parity_err_flag, tx_done_flag, no_ack_flag};

    chk_no_ack_flag_set: assert property (@(posedge core_clk) disable iff (rst)
        retryExhausted && !anyAck |=> no_ack_flag) else $error("no-ack flag not set");
    chk_txdone_set: assert property (@(posedge core_clk) disable iff (rst)
        txState_q == TX_IDLE && txEnd && txOk && !respRequested |=> tx_done_flag)
        else $error("tx-done flag not set");
    chk_resp_fail: assert property (@(posedge core_clk) disable iff (rst)
        txState_q == TX_WAIT_RESP && respEnd && !respOk && !tx_done_flag && !txEnd
        |=> !tx_done_flag) else $error("tx-done set on failed response");
    chk_parity_set: assert property (@(posedge core_clk) disable iff (rst)
        hostParityErr |=> host_parity_err_flag) else $error("parity flag not set");
    chk_rx_wake: assert property (@(posedge core_clk) disable iff (rst)
        sleepMode && wakeSrc == WAKE_ON_RX && rxChg |=> host_wake_flag)
        else $error("rx wake missed");
    chk_cs_wake: assert property (@(posedge core_clk) disable iff (rst)
        sleepMode && wakeSrc == WAKE_ON_CS && csChg |=> host_wake_flag)
        else $error("cs wake missed");
    chk_bus_wake: assert property (@(posedge core_clk) disable iff (rst)
        sleepMode && busChg && !busS |=> bus_wake_flag) else $error("bus wake missed");
    chk_pos_short: assert property (@(posedge core_clk) disable iff (rst)
        posChg && !posS |=> pos_line_gnd_short_flag) else $error("pos short missed");
    chk_neg_short: assert property (@(posedge core_clk) disable iff (rst)
        negChg && !negS |=> neg_line_gnd_short_flag) else $error("neg short missed");
    chk_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        no_ack_flag && !flagClear[`FLAG_NO_ACK] |=> no_ack_flag) else $error("flag dropped");
    chk_flags_hold: assert property (@(posedge core_clk) disable iff (rst)
        flagOut != `FLAG_RESET
        |=> (($past(flagOut) & ~$past(flagClear)) & ~flagOut) == `FLAG_RESET)
        else $error("flag dropped before clear");
    chk_flag_clear: assert property (@(posedge core_clk) disable iff (rst)
        flagClear[`FLAG_PARITY] && !hostParityErr |=> !host_parity_err_flag)
        else $error("parity flag not cleared");
    chk_any_flag: assert property (@(posedge core_clk) disable iff (rst)
        anyFlag == (|flagOut)) else $error("summary flag wrong");
    chk_wake_refused: assert property (@(posedge core_clk) disable iff (rst)
        !sleepMode && !host_wake_flag |=> !host_wake_flag)
        else $error("host wake while awake");
    chk_bus_refused: assert property (@(posedge core_clk) disable iff (rst)
        !sleepMode && !bus_wake_flag |=> !bus_wake_flag)
        else $error("bus wake while awake");
    chk_txdone_spur: assert property (@(posedge core_clk) disable iff (rst)
        !tx_done_flag && !txEnd && !respEnd |=> !tx_done_flag)
        else $error("tx-done without cause");

    // ************************************
    // cover points
    // ************************************

    cov_no_ack_flag: cover property (@(posedge core_clk) disable iff (rst) $rose(no_ack_flag));
    cov_resp_ok: cover property (@(posedge core_clk) disable iff (rst)
        txState_q == TX_WAIT_RESP ##1 $rose(tx_done_flag));
    cov_bus_wake: cover property (@(posedge core_clk) disable iff (rst) $rose(bus_wake_flag));
    cov_host_wake: cover property (@(posedge core_clk) disable iff (rst) $rose(host_wake_flag));
    cov_set_clear: cover property (@(posedge core_clk) disable iff (rst)
        hostParityErr && flagClear[`FLAG_PARITY]);
endmodule

// ===== bench/tx_engine_model.sv
`timescale 1ns/1ps

// *****************************
// transmit engine on the far side
// *****************************
module tx_engine_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // commands from the bench
    input wire logic go,
    input wire logic wantResp,
    input wire logic respGood,
    // events towards the flag logic
    output logic txEnd,
    output logic txOk,
    output logic respRequested,
    output logic respEnd,
    output logic respOk
);
    logic [2:0] wait_q;

    // message end with its qualifiers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txEnd <= 1'b0;
            txOk <= 1'b0;
            respRequested <= 1'b0;
        end else begin
            txEnd <= go;
            txOk <= go;
            respRequested <= go & wantResp;
        end
    end

    // requested response ends three cycles after the message
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 3'h0;
            respEnd <= 1'b0;
            respOk <= 1'b0;
        end else begin
            wait_q <= (go & wantResp) ? 3'h3 : ((wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0);
            respEnd <= (wait_q == 3'h1);
            respOk <= (wait_q == 3'h1) & respGood;
        end
    end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps

// *****************************
// flag logic bench
// *****************************
module tb_top;
    import lan_event_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    wake_src_t wakeSrc = WAKE_ON_RX;
    logic sleepMode = 1'b0;
    logic anyAck = 1'b0;
    logic [1:0] ev = 2'h0;
    logic [4:0] pins = 5'h00;
    logic [6:0] flagClear = 7'h00;
    logic go = 1'b0;
    logic wantResp = 1'b0;
    logic respGood = 1'b0;
    logic txEnd, txOk, respRequested, respEnd, respOk, anyFlag;
    logic [6:0] flags;
    int mismatches = 0;
    int n_compared = 0;

    always #20 core_clk = ~core_clk;

    tx_engine_model partner (.core_clk(core_clk), .rst(rst), .go(go), .wantResp(wantResp),
        .respGood(respGood), .txEnd(txEnd), .txOk(txOk), .respRequested(respRequested),
        .respEnd(respEnd), .respOk(respOk));

    lan_event_flag_logic dut (.core_clk(core_clk), .rst(rst), .wakeSrc(wakeSrc),
        .sleepMode(sleepMode), .retryExhausted(ev[0]), .anyAck(anyAck), .txEnd(txEnd),
        .txOk(txOk), .respRequested(respRequested), .respEnd(respEnd), .respOk(respOk),
        .hostParityErr(ev[1]), .rxPin(pins[0]), .csPin(pins[1]), .busLevel(pins[2]),
        .posGndShort(pins[3]), .negGndShort(pins[4]), .flagClear(flagClear),
        .no_ack_flag(flags[0]), .tx_done_flag(flags[1]), .host_parity_err_flag(flags[2]),
        .host_wake_flag(flags[3]), .bus_wake_flag(flags[4]),
        .pos_line_gnd_short_flag(flags[5]), .neg_line_gnd_short_flag(flags[6]),
        .anyFlag(anyFlag));

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input string what, input logic [6:0] exp);
        // look between edges, once this edge's flag updates have settled
        @(negedge core_clk);
        n_compared++;
        if ({anyFlag, flags} !== {|exp, exp}) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, {|exp, exp}, {anyFlag, flags});
        end
        @(posedge core_clk);
    endtask

    task automatic pulse(input logic [1:0] m);
        ev <= m;
        step(1);
        ev <= 2'h0;
        step(4);
    endtask

    task automatic pin(input logic [4:0] m);
        pins <= pins ^ m;
        step(6);
    endtask

    task automatic tx(input logic w, input logic g);
        wantResp <= w;
        respGood <= g;
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        step(8);
    endtask

    task automatic clr();
        flagClear <= 7'h7F;
        step(1);
        flagClear <= 7'h00;
        step(2);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        step(1000);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        step(4);
        rst <= 1'b0;
        anyAck <= 1'b1;
        pulse(2'h1);
        chk("acked retry", 7'h00);
        anyAck <= 1'b0;
        pulse(2'h1);
        step(3);
        chk("no ack sticky", 7'h01);
        clr();
        chk("cleared", 7'h00);
        tx(1'b0, 1'b0);
        chk("tx done", 7'h02);
        clr();
        tx(1'b1, 1'b0);
        chk("bad response", 7'h00);
        tx(1'b1, 1'b1);
        chk("good response", 7'h02);
        clr();
        pulse(2'h2);
        chk("host parity", 7'h04);
        clr();
        pin(5'h05);
        chk("awake pins", 7'h00);
        pin(5'h05);
        sleepMode <= 1'b1;
        step(1);
        pin(5'h01);
        chk("rx wake", 7'h08);
        clr();
        wakeSrc <= WAKE_ON_CS;
        pin(5'h02);
        chk("cs wake", 7'h08);
        clr();
        pin(5'h04);
        chk("bus wake", 7'h10);
        clr();
        pin(5'h08);
        chk("pos short", 7'h20);
        pin(5'h10);
        chk("neg short", 7'h60);
        clr();
        chk("final clear", 7'h00);
        flagClear <= 7'h7F;
        ev <= 2'h2;
        step(1);
        flagClear <= 7'h00;
        ev <= 2'h0;
        step(2);
        chk("set beats clear", 7'h04);
        tally_and_finish();
    end
endmodule
